/* File: pkg/smart_card_map.vh */
`ifndef SMART_CARD_MAP_VH
`define SMART_CARD_MAP_VH

// ****************************************************
// Timing
// ****************************************************
`define MCLK_PERIOD_NS   20
`define HALF_PERIOD_NS   80
// Card clock half period in mclk cycles: 80 ns halves of a 20 ns clock
`define HALF_CYCLES      8'h04
`define ETU_LAST         9'h173
`define SAMPLE_TICK      9'h0b9
`define BIT_PARITY       4'h9
`define BIT_ERR_SLOT     4'ha
`define BIT_RX_END       4'hb
`define BIT_TRANSMIT_END_FLAG_STD     4'hc
`define BIT_RETRY        4'hc
`define BIT_ZERO         4'h0
`define BIT_ONE          4'h1
`define CNT_ZERO         9'h000
`define CNT_ONE          9'h001

// ****************************************************
// Register offsets
// ****************************************************
`define OFF_MODE         8'h00
`define OFF_CTRL         8'h04
`define OFF_STATUS       8'h08
`define OFF_TXDATA       8'h0c
`define OFF_RXDATA       8'h10
`define OFF_CARDMODE     8'h14

// ****************************************************
// Fields
// ****************************************************
`define MODE_GM          0
`define MODE_ODD         1
`define CTRL_CLKOUT      0
`define CTRL_CLKLVL      1
`define CTRL_RXON        4
`define CTRL_TXEN        5
`define CTRL_RIE         6
`define CTRL_TIE         7
`define ST_PIN           0
`define ST_TRANSMIT_END_FLAG          2
`define ST_ERS           3
`define ST_PER           4
`define ST_OVERRUN_FLAG          5
`define ST_RX_FULL_FLAG          6
`define ST_TRANSMIT_EMPTY_FLAG          7
`define CM_SMIF          0
`define CM_SINV          2
`define CM_SDIR          3

// ****************************************************
// Reset values and responses
// ****************************************************
`define RST_BYTE         8'h00
`define RST_WORD         32'h00000000
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

/* File: rtl/half_divider.v */
`timescale 1ns/1ps
module half_divider #(
	parameter [7:0] COUNT = 8'h04
) (
	// Clock and control
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       clk_en,
	input  wire       clear,
	// Tick out
	output reg        tick
);
	reg [7:0] cnt;

	// Clear restarts the phase so a restarted clock keeps full halves
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			cnt  <= 8'h00;
			tick <= 1'b0;
		end
		else if (clk_en)
		begin
			if (clear || cnt == COUNT - 8'h01)
			begin
				cnt  <= 8'h00;
				tick <= ~clear;
			end
			else
			begin
				cnt  <= cnt + 8'h01;
				tick <= 1'b0;
			end
		end
	end
endmodule

/* File: rtl/smart_card_serial.v */
`timescale 1ns/1ps
`include "smart_card_map.vh"
// Notes on behaviour
// - Data write plus empty clear starts send
// - End flag raises transmit ready irq
// - Card error flag raises link fault irq
// - End flag point depends on gated mode
// - Receive done sets full flag, irqs
// - Parity error still loads received byte
// - Gated mode fixes clock level by bits
// - Only three irqs; transmit done never
// - Fault irq never requests DMA
// - End flag also sets empty; DMA clears
// - Card error resends byte, end stays low
// - Error signal flag cleared only by software
// - Receive error: no full flag, no DMA
// - Clock stop finishes cycle, then holds
// - Clock restarts with normal duty cycle
// - 372 ticks per bit, sample at 186
// - Error-free receive leaves line released while parity error flag is clear
module smart_card_serial (
	// Clock, reset, enable
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        clk_en,
	// AXI4-Lite slave
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// Card link
	input  wire        card_data_in,
	output reg         card_data_out,
	output reg         card_data_oe,
	output reg         card_clk,
	// DMA side
	input  wire        dma_tx_wr,
	input  wire [7:0]  dma_tx_data,
	input  wire        dma_rx_rd,
	output reg  [7:0]  dma_rx_data,
	output reg         dma_tx_req,
	output reg         dma_rx_req,
	// Interrupt requests
	output reg         tx_ready_irq,
	output reg         rx_ready_irq,
	output reg         link_fault_irq,
	output reg         tx_done_irq
);
	localparam [3:0] T_IDLE  = 4'b0001;
	localparam [3:0] T_SEND  = 4'b0010;
	localparam [3:0] T_GUARD = 4'b0100;
	localparam [3:0] T_RETRY = 4'b1000;
	localparam [3:0] R_IDLE  = 4'b0001;
	localparam [3:0] R_RECV  = 4'b0010;
	localparam [3:0] R_ERR   = 4'b0100;
	localparam [3:0] R_GUARD = 4'b1000;

	// ****************************************************
	// Registers and state
	// ****************************************************
	reg [7:0]  serial_mode_reg;
	reg [7:0]  serial_ctrl_reg;
	reg [7:0]  card_mode_reg;
	reg [7:0]  transmit_data_reg;
	reg [7:0]  rx_data_reg;
	reg        transmit_end_flag;
	reg        transmit_empty_flag;
	reg        error_signal_flag;
	reg        parity_error_flag;
	reg        overrun_flag;
	reg        rx_full_flag;
	reg        aw_full;
	reg        w_full;
	reg [7:0]  aw_q;
	reg [31:0] w_q;
	reg [3:0]  strb_q;
	reg [3:0]  tx_state;
	reg [8:0]  tx_cnt;
	reg [3:0]  tx_idx;
	reg [9:0]  tx_shift;
	reg        err_seen;
	reg [3:0]  rx_state;
	reg [8:0]  rx_cnt;
	reg [3:0]  rx_idx;
	reg [7:0]  rx_raw;
	reg        rx_par;
	reg        line_s1;
	reg        line_s2;
	reg        line_prev;
	reg        base_phase;
	reg        clk_run;
	wire       half_tick;

	wire gm     = serial_mode_reg[`MODE_GM];
	wire odd    = serial_mode_reg[`MODE_ODD];
	wire smif   = card_mode_reg[`CM_SMIF];
	wire sinv   = card_mode_reg[`CM_SINV];
	wire sdir   = card_mode_reg[`CM_SDIR];
	wire tx_en  = serial_ctrl_reg[`CTRL_TXEN];
	wire rx_on  = serial_ctrl_reg[`CTRL_RXON];
	wire tx_irq_mask    = serial_ctrl_reg[`CTRL_TIE];
	wire rx_err_irq_mask    = serial_ctrl_reg[`CTRL_RIE];
	wire clkout = serial_ctrl_reg[`CTRL_CLKOUT];
	wire clklvl = serial_ctrl_reg[`CTRL_CLKLVL];

	function [7:0] reverse8;
		input [7:0] v;
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1)
				reverse8[k] = v[7 - k];
		end
	endfunction

	// ****************************************************
	// Bus decode
	// ****************************************************
	wire       wr_now  = aw_full & w_full & ~bvalid;
	wire       wr_lo   = wr_now & strb_q[0];
	wire       wr_stat = wr_lo & (aw_q == `OFF_STATUS);
	wire       wr_tdr  = wr_lo & (aw_q == `OFF_TXDATA);
	wire       wr_map  = (aw_q == `OFF_MODE) | (aw_q == `OFF_CTRL) |
	                     (aw_q == `OFF_STATUS) | (aw_q == `OFF_TXDATA) |
	                     (aw_q == `OFF_RXDATA) | (aw_q == `OFF_CARDMODE);
	wire [7:0] status  = {transmit_empty_flag, rx_full_flag, overrun_flag,
	                      parity_error_flag, error_signal_flag,
	                      transmit_end_flag, 1'b0, card_clk};

	reg [31:0] rd_word;
	reg        rd_ok;
	always @*
	begin
		rd_word = `RST_WORD;
		rd_ok   = 1'b1;
		case (araddr)
		`OFF_MODE:     rd_word[7:0] = serial_mode_reg;
		`OFF_CTRL:     rd_word[7:0] = serial_ctrl_reg;
		`OFF_STATUS:   rd_word[7:0] = status;
		`OFF_TXDATA:   rd_word[7:0] = transmit_data_reg;
		`OFF_RXDATA:   rd_word[7:0] = rx_data_reg;
		`OFF_CARDMODE: rd_word[7:0] = card_mode_reg;
		default:       rd_ok = 1'b0;
		endcase
	end

	// Frame contents, convention applied; parity sees coded bits only
	wire [7:0] tx_coded = sinv ? ~transmit_data_reg : transmit_data_reg;
	wire [7:0] tx_order = sdir ? reverse8(tx_coded) : tx_coded;
	wire [9:0] tx_frame = {(^tx_order) ^ odd, tx_order, 1'b0};
	wire [7:0] rx_order = sdir ? reverse8(rx_raw) : rx_raw;
	wire [7:0] rx_byte  = sinv ? ~rx_order : rx_order;
	wire       rx_bad   = (^rx_raw) ^ rx_par ^ odd;

	wire       base_tick = half_tick & base_phase;
	wire       tx_last   = base_tick & (tx_cnt == `ETU_LAST);
	wire       tx_samp   = base_tick & (tx_cnt == `SAMPLE_TICK);
	wire       rx_last   = base_tick & (rx_cnt == `ETU_LAST);
	wire       rx_samp   = base_tick & (rx_cnt == `SAMPLE_TICK);
	wire       tx_start  = (tx_state == T_IDLE) & tx_en & smif &
	                       ~transmit_empty_flag;
	wire       tx_done   = (tx_state == T_GUARD) &
	                       ((gm & tx_last & (tx_idx == `BIT_ERR_SLOT) &
	                         ~err_seen) |
	                        (~gm & tx_samp &
	                         (tx_idx == `BIT_TRANSMIT_END_FLAG_STD)));
	wire       tx_error  = (tx_state == T_GUARD) & tx_last &
	                       (tx_idx == `BIT_ERR_SLOT) & err_seen;
	wire       rx_end    = (rx_state == R_RECV) & rx_last &
	                       (rx_idx == `BIT_PARITY);
	wire       rx_good   = rx_end & ~rx_full_flag & ~rx_bad;

	// ****************************************************
	// Card clock
	// ****************************************************
	wire clk_stop = ~clk_run & ~(smif & clkout);

	half_divider #(
		.COUNT   (`HALF_CYCLES)
	) u_half (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.clear   (clk_stop),
		.tick    (half_tick)
	);

	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			card_clk   <= 1'b0;
			clk_run    <= 1'b0;
			base_phase <= 1'b0;
		end
		else if (clk_en)
		begin
			if (clk_stop)
			begin
				// Held level follows the fixed-level bit when gated
				card_clk   <= gm & clklvl;
				base_phase <= 1'b0;
			end
			else if (half_tick)
			begin
				base_phase <= ~base_phase;
				// Stop only on the fixed level: no phase is cut short
				if (!(smif & clkout) && card_clk == (gm & clklvl))
					clk_run <= 1'b0;
				else
				begin
					card_clk <= ~card_clk;
					clk_run  <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// Bus slave, flags, transmit and receive
	// ****************************************************
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			awready <= 1'b1;
			wready  <= 1'b1;
			arready <= 1'b1;
			bvalid  <= 1'b0;
			rvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
			rresp   <= `RESP_OKAY;
			rdata   <= `RST_WORD;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_q    <= `RST_BYTE;
			w_q     <= `RST_WORD;
			strb_q  <= 4'h0;
			serial_mode_reg     <= `RST_BYTE;
			serial_ctrl_reg     <= `RST_BYTE;
			card_mode_reg       <= `RST_BYTE;
			transmit_data_reg   <= `RST_BYTE;
			rx_data_reg         <= `RST_BYTE;
			transmit_end_flag   <= 1'b1;
			transmit_empty_flag <= 1'b1;
			error_signal_flag   <= 1'b0;
			parity_error_flag   <= 1'b0;
			overrun_flag        <= 1'b0;
			rx_full_flag        <= 1'b0;
			tx_state <= T_IDLE;
			tx_cnt   <= `CNT_ZERO;
			tx_idx   <= `BIT_ZERO;
			tx_shift <= 10'h3ff;
			err_seen <= 1'b0;
			rx_state <= R_IDLE;
			rx_cnt   <= `CNT_ZERO;
			rx_idx   <= `BIT_ZERO;
			rx_raw   <= `RST_BYTE;
			rx_par   <= 1'b0;
			line_s1  <= 1'b1;
			line_s2  <= 1'b1;
			line_prev <= 1'b1;
			card_data_out  <= 1'b0;
			card_data_oe   <= 1'b0;
			dma_rx_data    <= `RST_BYTE;
			dma_tx_req     <= 1'b0;
			dma_rx_req     <= 1'b0;
			tx_ready_irq   <= 1'b0;
			rx_ready_irq   <= 1'b0;
			link_fault_irq <= 1'b0;
			tx_done_irq    <= 1'b0;
		end
		else if (clk_en)
		begin
			line_s1   <= card_data_in;
			line_s2   <= line_s1;
			line_prev <= line_s2;
			// Write channels, taken in either order
			if (awvalid && awready)
			begin
				aw_q    <= awaddr;
				aw_full <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_q    <= wdata;
				strb_q <= wstrb;
				w_full <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_now)
			begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
				if (strb_q[0] && aw_q == `OFF_MODE)
					serial_mode_reg <= w_q[7:0];
				if (strb_q[0] && aw_q == `OFF_CTRL)
					serial_ctrl_reg <= w_q[7:0];
				if (strb_q[0] && aw_q == `OFF_CARDMODE)
					card_mode_reg <= w_q[7:0];
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_word;
				rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (rvalid && rready)
			begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end

			// Flag clears first; hardware sets below win in the same cycle
			if (wr_stat && !w_q[`ST_ERS])
				error_signal_flag <= 1'b0;
			if (wr_stat && !w_q[`ST_PER])
				parity_error_flag <= 1'b0;
			if (wr_stat && !w_q[`ST_OVERRUN_FLAG])
				overrun_flag <= 1'b0;
			if ((wr_stat && !w_q[`ST_RX_FULL_FLAG]) || dma_rx_rd)
				rx_full_flag <= 1'b0;
			if (wr_stat && !w_q[`ST_TRANSMIT_EMPTY_FLAG])
				transmit_empty_flag <= 1'b0;
			if (wr_tdr)
				transmit_data_reg <= w_q[7:0];
			if (dma_tx_wr)
			begin
				transmit_data_reg   <= dma_tx_data;
				transmit_empty_flag <= 1'b0;
				transmit_end_flag   <= 1'b0;
			end

			// Transmit: one bit is 372 base ticks
			if (base_tick)
				tx_cnt <= tx_last ? `CNT_ZERO : tx_cnt + `CNT_ONE;
			if (tx_last)
				tx_idx <= tx_idx + `BIT_ONE;
			case (tx_state)
			T_IDLE:
				if (tx_start)
				begin
					tx_shift <= tx_frame;
					tx_cnt   <= `CNT_ZERO;
					tx_idx   <= `BIT_ZERO;
					tx_state <= T_SEND;
					transmit_end_flag <= 1'b0;
				end
			T_SEND:
				if (tx_last)
				begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					if (tx_idx == `BIT_PARITY)
					begin
						err_seen <= 1'b0;
						tx_state <= T_GUARD;
					end
				end
			T_GUARD:
			begin
				if (tx_samp && tx_idx == `BIT_ERR_SLOT)
					err_seen <= ~line_s2;
				if (tx_error)
				begin
					error_signal_flag <= 1'b1;
					tx_state <= T_RETRY;
				end
				if (tx_done)
				begin
					transmit_end_flag   <= 1'b1;
					transmit_empty_flag <= 1'b1;
					tx_state <= T_IDLE;
				end
			end
			T_RETRY:
				// End flag stays low through the resend of the same byte
				if (!tx_en)
					tx_state <= T_IDLE;
				else if (tx_last && tx_idx == `BIT_RETRY)
				begin
					tx_shift <= tx_frame;
					tx_idx   <= `BIT_ZERO;
					tx_state <= T_SEND;
				end
			default:
				tx_state <= T_IDLE;
			endcase

			// Receive: align to falling start edge, sample mid-bit
			if (base_tick)
				rx_cnt <= rx_last ? `CNT_ZERO : rx_cnt + `CNT_ONE;
			if (rx_last)
				rx_idx <= rx_idx + `BIT_ONE;
			case (rx_state)
			R_IDLE:
				if (rx_on && smif && line_prev && !line_s2)
				begin
					rx_cnt   <= `CNT_ZERO;
					rx_idx   <= `BIT_ZERO;
					rx_state <= R_RECV;
				end
			R_RECV:
			begin
				if (rx_samp && rx_idx == `BIT_ZERO && line_s2)
					rx_state <= R_IDLE;
				else if (rx_samp && rx_idx == `BIT_PARITY)
					rx_par <= line_s2;
				else if (rx_samp)
					rx_raw <= {line_s2, rx_raw[7:1]};
				if (rx_end)
				begin
					rx_state <= R_GUARD;
					if (rx_full_flag)
						overrun_flag <= 1'b1;
					else if (rx_bad)
					begin
						parity_error_flag <= 1'b1;
						rx_data_reg <= rx_byte;
					end
					if (rx_good)
					begin
						rx_full_flag <= 1'b1;
						rx_data_reg  <= rx_byte;
					end
				end
			end
			R_GUARD:
				if (rx_samp && rx_idx == `BIT_ERR_SLOT && parity_error_flag)
					rx_state <= R_ERR;
				else if (rx_last && rx_idx == `BIT_RX_END)
					rx_state <= R_IDLE;
			R_ERR:
				// Line pulled low for one bit time as the error signal
				if (rx_samp && rx_idx == `BIT_RX_END)
					rx_state <= R_GUARD;
			default:
				rx_state <= R_IDLE;
			endcase

			// Line drive: released except while sending or signalling
			card_data_oe  <= (tx_state == T_SEND) | (rx_state == R_ERR);
			card_data_out <= (tx_state == T_SEND) & tx_shift[0];

			dma_rx_data    <= rx_data_reg;
			tx_ready_irq   <= transmit_end_flag & tx_irq_mask;
			rx_ready_irq   <= rx_full_flag & rx_err_irq_mask;
			link_fault_irq <= (error_signal_flag | parity_error_flag |
			                   overrun_flag) & rx_err_irq_mask;
			// Fault irq has no DMA path; only ready events request
			dma_tx_req     <= transmit_end_flag & tx_irq_mask;
			dma_rx_req     <= rx_full_flag & rx_err_irq_mask;
			tx_done_irq    <= 1'b0;
		end
	end
endmodule

/* File: sim/card_model.sv */
`timescale 1ns/1ps
module card_model (
	// Link
	input  wire  card_clk,
	input  wire  line,
	output logic pull_low
);
	initial pull_low = 1'b0;
	task automatic ticks(input int n);
		repeat (n) @(posedge card_clk);
	endtask
	// Card only pulls low; released line rests at the pull-up
	task automatic take_frame(input bit nack, output logic [9:0] bits);
	begin
		@(negedge line);
		ticks(186);
		for (int i = 0; i < 10; i++)
		begin
			bits[i] = line;
			if (i < 9)
				ticks(372);
		end
		ticks(186);
		pull_low = nack;
		ticks(372);
		pull_low = 1'b0;
	end
	endtask
	task automatic give_frame(input logic [9:0] bits, output bit quiet);
	begin
		quiet = 1'b1;
		@(posedge card_clk);
		for (int i = 0; i < 10; i++)
		begin
			pull_low = !bits[i];
			ticks(372);
		end
		pull_low = 1'b0;
		// One bit time covers the start of any error drive
		repeat (372)
		begin
			@(posedge card_clk);
			if (!line)
				quiet = 1'b0;
		end
	end
	endtask
endmodule

/* File: sim/smart_card_serial_sva.sv */
`timescale 1ns/1ps
module smart_card_serial_sva (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	input wire clk_en,
	// Bus and DMA
	input wire wvalid,
	input wire wready,
	input wire dma_tx_wr,
	input wire dma_rx_rd,
	input wire dma_tx_req,
	input wire dma_rx_req,
	// Card link and interrupts
	input wire card_data_out,
	input wire card_data_oe,
	input wire card_clk,
	input wire tx_ready_irq,
	input wire rx_ready_irq,
	input wire link_fault_irq,
	input wire tx_done_irq
);
	int unsigned oe_len;
	int unsigned wr_age;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ****************************************************
	// Helpers
	// ****************************************************
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			oe_len <= 0;
			wr_age <= 100;
		end
		else
		begin
			oe_len <= card_data_oe ? oe_len + 1 : 0;
			if (wvalid && wready)
				wr_age <= 0;
			else if (wr_age < 100)
				wr_age <= wr_age + 1;
		end
	end
	// ****************************************************
	// Properties
	// ****************************************************
	property p_no_tx_done;
		tx_done_irq == 1'b0;
	endproperty
	a_no_tx_done: assert property (p_no_tx_done)
		else $error("transmit done irq raised");
	property p_fault_no_dma;
		$rose(link_fault_irq) |-> !$rose(dma_tx_req) && !$rose(dma_rx_req);
	endproperty
	a_fault_no_dma: assert property (p_fault_no_dma)
		else $error("fault raised a dma request");
	property p_tx_irq;
		$rose(tx_ready_irq) |-> !card_data_oe;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("transmit irq during frame drive");
	property p_rx_irq;
		$rose(rx_ready_irq) |-> !card_data_oe;
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("receive irq during error drive");
	property p_wr_clear;
		dma_tx_wr && clk_en && dma_tx_req |-> ##[1:3] !dma_tx_req;
	endproperty
	a_wr_clear: assert property (p_wr_clear)
		else $error("dma write left end flag set");
	property p_rd_clear;
		dma_rx_rd && clk_en && dma_rx_req |-> ##[1:3] !dma_rx_req;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("dma read left full flag set");
	property p_clk_high;
		$rose(card_clk) |=> card_clk [*3];
	endproperty
	a_clk_high: assert property (p_clk_high)
		else $error("card clock high phase short");
	property p_clk_low;
		$fell(card_clk) |=> !card_clk [*3];
	endproperty
	a_clk_low: assert property (p_clk_low)
		else $error("card clock low phase short");
	property p_start_low;
		$rose(card_data_oe) |-> ##[0:1] !card_data_out;
	endproperty
	a_start_low: assert property (p_start_low)
		else $error("drive did not begin low");
	property p_oe_len;
		$fell(card_data_oe) |-> oe_len >= 2900 && oe_len <= 29800;
	endproperty
	a_oe_len: assert property (p_oe_len)
		else $error("drive burst length wrong");
	property p_fault_clear;
		$fell(link_fault_irq) |-> wr_age <= 6;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("fault cleared without a write");
	c_fault: cover property ($rose(link_fault_irq));
	c_tx: cover property ($rose(tx_ready_irq));
	c_rx: cover property ($rose(rx_ready_irq));
endmodule
bind smart_card_serial smart_card_serial_sva smart_card_serial_sva_inst (
	.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
	.wvalid(wvalid), .wready(wready), .dma_tx_wr(dma_tx_wr),
	.dma_rx_rd(dma_rx_rd), .dma_tx_req(dma_tx_req),
	.dma_rx_req(dma_rx_req), .card_data_out(card_data_out),
	.card_data_oe(card_data_oe), .card_clk(card_clk),
	.tx_ready_irq(tx_ready_irq), .rx_ready_irq(rx_ready_irq),
	.link_fault_irq(link_fault_irq), .tx_done_irq(tx_done_irq));

/* File: sim/smart_card_serial_tb_top.sv */
`timescale 1ns/1ps
module smart_card_serial_tb_top;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dma_tx_data = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [7:0]   dma_rx_data;
	wire         card_data_out, card_data_oe, card_clk, pull_low, line;
	wire         dma_tx_req, dma_rx_req, tx_ready_irq, rx_ready_irq;
	wire         link_fault_irq, tx_done_irq;
	wire [2:0]   irqs = {rx_ready_irq, link_fault_irq, tx_ready_irq};
	int          miscompares = 0;
	int          total_checks = 0;
	int          cycles = 0;
	// Open-drain data line with pull-up
	assign line = (card_data_oe ? card_data_out : 1'b1) & ~pull_low;
	always #10 mclk = ~mclk;
	smart_card_serial smart_card_serial_inst (
		.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.card_data_in(line), .card_data_out(card_data_out),
		.card_data_oe(card_data_oe), .card_clk(card_clk),
		.dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
		.dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data),
		.dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
		.tx_ready_irq(tx_ready_irq), .rx_ready_irq(rx_ready_irq),
		.link_fault_irq(link_fault_irq), .tx_done_irq(tx_done_irq));
	card_model card_model_inst (.card_clk(card_clk), .line(line),
		.pull_low(pull_low));
	// ****************************************************
	// Shared tasks
	// ****************************************************
	task automatic chk(input logic [31:0] got, exp, input string what);
	begin
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, what);
		end
	end
	endtask
	task automatic results;
	begin
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 110000)
		begin
			miscompares++;
			results();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
	begin
		done = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit done;
	begin
		done = 1'b0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				done = 1'b1;
			end
		end
	end
	endtask
	task automatic wait_irq(input int sel, input int limit, output int n);
	begin
		n = 0;
		while (n < limit && irqs[sel] !== 1'b1)
		begin
			@(posedge mclk);
			n++;
		end
	end
	endtask
	// ****************************************************
	// Scenarios
	// ****************************************************
	task automatic test_regs;
		logic [31:0] d;
		logic [1:0]  r;
	begin
		rd(8'h08, d, r);
		chk(d, 32'h84, "status after reset");
		rd(8'h18, d, r);
		chk(d, 32'h0, "unmapped read data");
		chk(r, 32'h2, "unmapped read response");
		wr(8'h00, 32'h3);
		rd(8'h00, d, r);
		chk(d, 32'h3, "mode readback");
		$display("test regs done");
	end
	endtask
	task automatic test_tx;
		logic [31:0] d;
		logic [1:0]  r;
		logic [9:0]  f;
		int          n;
	begin
		wr(8'h00, 32'h1);
		wr(8'h14, 32'h1);
		wr(8'h04, 32'he1);
		wait_irq(0, 10, n);
		chk(tx_ready_irq, 32'h1, "transmit irq idle");
		chk(dma_tx_req, 32'h1, "transmit dma idle");
		rd(8'h08, d, r);
		chk(d & 32'h0c, 32'h04, "ready to send");
		fork
			card_model_inst.take_frame(1'b1, f);
			begin
				@(posedge mclk);
				dma_tx_data <= 8'h3b;
				dma_tx_wr <= 1'b1;
				@(posedge mclk);
				dma_tx_wr <= 1'b0;
				rd(8'h08, d, r);
				chk(d & 32'hfc, 32'h0, "flags at start");
			end
		join
		chk(f, {1'b1, 8'h3b, 1'b0}, "first frame");
		wait_irq(1, 3000, n);
		chk(link_fault_irq, 32'h1, "fault irq");
		rd(8'h08, d, r);
		chk(d & 32'hfc, 32'h08, "flags after nack");
		card_model_inst.take_frame(1'b0, f);
		chk(f, {1'b1, 8'h3b, 1'b0}, "resent frame");
		wait_irq(0, 6000, n);
		// Gated mode: end flag at the close of the error slot
		chk(n < 16, 32'h1, "end flag point");
		rd(8'h08, d, r);
		chk(d & 32'hfc, 32'h8c, "flags after resend");
		wr(8'h08, 32'hf7);
		rd(8'h08, d, r);
		chk(d & 32'hfc, 32'h84, "error flag cleared");
		chk(link_fault_irq, 32'h0, "fault irq cleared");
		$display("test tx done");
	end
	endtask
	task automatic test_clock;
		int   n;
		logic p;
	begin
		wr(8'h04, 32'h02);
		repeat (9) @(posedge mclk);
		chk(card_clk, 32'h1, "clock stopped high");
		repeat (40) @(posedge mclk);
		chk(card_clk, 32'h1, "clock held high");
		wr(8'h04, 32'h00);
		repeat (9) @(posedge mclk);
		chk(card_clk, 32'h0, "clock fixed low");
		wr(8'h04, 32'h01);
		n = 0;
		p = card_clk;
		repeat (80)
		begin
			@(posedge mclk);
			if (card_clk && !p)
				n++;
			p = card_clk;
		end
		chk(n >= 9 && n <= 11, 32'h1, "clock restart rate");
		$display("test clock done");
	end
	endtask
	task automatic test_rx;
		logic [31:0] d;
		logic [1:0]  r;
		bit          q;
	begin
		wr(8'h04, 32'h51);
		card_model_inst.give_frame({1'b0, 8'ha5, 1'b0}, q);
		chk(q, 32'h1, "line left released");
		chk(rx_ready_irq, 32'h1, "receive irq");
		chk(dma_rx_req, 32'h1, "receive dma request");
		chk(dma_rx_data, 32'ha5, "dma receive data");
		rd(8'h10, d, r);
		chk(d, 32'ha5, "receive data");
		rd(8'h08, d, r);
		chk(d & 32'hfc, 32'hc4, "flags after receive");
		@(posedge mclk);
		dma_rx_rd <= 1'b1;
		@(posedge mclk);
		dma_rx_rd <= 1'b0;
		rd(8'h08, d, r);
		chk(d & 32'hfc, 32'h84, "full cleared by dma");
		$display("test rx done");
	end
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		test_regs();
		test_tx();
		test_clock();
		test_rx();
		results();
	end
endmodule
